// [scss_clk_select.v]
// Functional notes
// RL1: Source after every reset comes from the configured reset oscillator selection.
// RL2: An external reset source also uses the configured external mode field.
// RL3: Mode field picks one of three external clock or three crystal modes.
// RL4: Clock modes take the logic level directly; crystal modes drive a crystal.
// RL5: Loss of an external source falls back to the internal oscillator.
// RL6: Crystal sources are used only after the start-up timer has counted.
// RL7: Two internal oscillators serve as sources, speed set by software.
// RL8: Secondary oscillator takes a crystal or a clock on its own pin.
// RL9: Software may select the secondary oscillator at run time.
// RL10: Internal reset selection makes the internal source the default after reset.
// RL11: Writing the new source field switches to the internal oscillator; the code switches to whichever legal source is written.
// RL12: On an internal clock the primary pins serve as I/O or clock output.
// RL13: Configured clock-output enable picks I/O or clock output on the output pin.
// RL14: High-frequency internal oscillator set by frequency and tuning registers.
// RL15: Low-frequency internal oscillator runs fixed and may be the source.
// RL16: A switch keeps the old source until the new one is ready, glitch free.
// RL17: A fail-safe fallback sets a readable flag that can raise an interrupt; in qualification it sets failsafe_q and the done flag, not the fail flag.
`timescale 1ns/1ps
`default_nettype none
`include "scss_defs.vh"
module scss_clk_select #(
  parameter OST_EDGES   = `SCSS_OST_EDGES,
  parameter LOSS_CYCLES = `SCSS_LOSS_CYCLES,
  parameter INT_SETTLE  = `SCSS_INT_SETTLE
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire        ce,
  input  wire [2:0]  reset_osc_select,
  input  wire [2:0]  ext_osc_mode_select,
  input  wire        clock_out_pin_enable,
  input  wire        primary_osc_in_pin,
  input  wire        secondary_clock_input,
  input  wire        secondary_use_crystal,
  input  wire [4:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [2:0]  active_source_q,
  output reg  [2:0]  ext_mode_q,
  output reg         primary_xtal_drive_q,
  output reg         secondary_xtal_drive_q,
  output reg         primary_in_is_gpio_q,
  output reg         primary_out_is_clkout_q,
  output reg         primary_out_is_gpio_q,
  output reg         clk_gate_q,
  output reg  [3:0]  hf_freq_out_q,
  output reg  [5:0]  hf_tune_out_q,
  output reg         irq_q
);
  localparam ST_RUN    = 2'h0;
  localparam ST_QUAL   = 2'h1;
  localparam ST_GATE   = 2'h2;
  localparam ST_BOOT   = 2'h3;

  reg [1:0]                state_q;
  reg [2:0]                target_q;
  reg [7:0]                settle_q;
  reg [2:0]                new_osc_select_q;
  reg [`SCSS_FREQ_W-1:0]   hf_freq_select_reg_q;
  reg [`SCSS_TUNE_W-1:0]   hf_fine_tune_reg_q;
  reg [`SCSS_IRQ_W-1:0]    irq_stat_q;
  reg [`SCSS_IRQ_W-1:0]    irq_mask_q;
  reg                      failsafe_q;
  reg [2:0]                cfg_src_q;
  reg [2:0]                cfg_mode_q;
  reg                      cfg_clkout_q;
  reg                      cfg_sec_xtal_q;
  wire [1:0]               mon_ready;
  wire [1:0]               mon_lost;
  wire [1:0]               mon_enable;
  wire [1:0]               mon_use_ost;
  wire [1:0]               mon_level;

  // ============================================================
  // Decoding helpers, all but is_internal used in more than one place.
  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = (mode == `SCSS_XTAL_LOW) || (mode == `SCSS_XTAL_MED) ||
                   (mode == `SCSS_XTAL_HIGH); // [RL4]
    end
  endfunction

  function is_internal;
    input [2:0] src;
    begin
      is_internal = (src == `SCSS_SRC_HFINT) || (src == `SCSS_SRC_LFINT);
    end
  endfunction

  function [2:0] legal_src;
    input [2:0] src;
    begin
      // Unused codes fall back to the high-frequency internal source.
      if (src == `SCSS_SRC_EXT || src == `SCSS_SRC_LFINT || src == `SCSS_SRC_SEC) begin
        legal_src = src;
      end else begin
        legal_src = `SCSS_SRC_HFINT;
      end
    end
  endfunction

  // ============================================================
  // Source monitors: slot 0 watches the primary pin, slot 1 the secondary.
  assign mon_level[0]   = primary_osc_in_pin;
  assign mon_level[1]   = secondary_clock_input;
  assign mon_use_ost[0] = is_crystal(cfg_mode_q); // [RL6]
  assign mon_use_ost[1] = cfg_sec_xtal_q; // [RL8]
  assign mon_enable[0]  = (active_source_q == `SCSS_SRC_EXT) ||
                          (target_q == `SCSS_SRC_EXT && state_q == ST_QUAL);
  assign mon_enable[1]  = (active_source_q == `SCSS_SRC_SEC) ||
                          (target_q == `SCSS_SRC_SEC && state_q == ST_QUAL);

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_mon
      scss_src_mon #(
        .OST_EDGES   (OST_EDGES),
        .LOSS_CYCLES (LOSS_CYCLES)
      ) u_mon (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .ce        (ce),
        .enable    (mon_enable[gi]),
        .use_ost   (mon_use_ost[gi]),
        .src_level (mon_level[gi]),
        .ready_q   (mon_ready[gi]),
        .lost_q    (mon_lost[gi])
      );
    end
  endgenerate

  // ============================================================
  // Readiness of the requested source and loss of the active one.
  // A target that never starts leaves qualification waiting on the old source,
  // which keeps the system clocked; the status word shows the stall.
  reg target_ready;
  reg active_lost;
  always @* begin
    case (target_q)
      `SCSS_SRC_EXT: target_ready = mon_ready[0];
      `SCSS_SRC_SEC: target_ready = mon_ready[1];
      default:       target_ready = (settle_q == INT_SETTLE[7:0]); // [RL7] [RL15]
    endcase
    case (active_source_q)
      `SCSS_SRC_EXT: active_lost = mon_lost[0]; // [RL5]
      `SCSS_SRC_SEC: active_lost = mon_lost[1];
      default:       active_lost = 1'b0;
    endcase
  end

  // ============================================================
  // Bus decode. Writes land on the edge where waitrequest is seen low.
  wire       bus_done = (avs_read | avs_write) & ~avs_waitrequest;
  wire       wr_done  = avs_write & ~avs_waitrequest;
  wire [2:0] word_idx = avs_address[4:2];
  wire       sw_switch = wr_done && word_idx == `SCSS_REG_CTRL;
  wire       fail_evt  = active_lost && state_q == ST_RUN;
  wire       done_evt  = state_q == ST_GATE;

  // ============================================================
  // Switch sequencer. The old source stays selected through
  // qualification; the gate is then held low one cycle so the
  // downstream mux never sees a shortened pulse at change-over.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_q         <= ST_BOOT;
      target_q        <= `SCSS_SRC_HFINT;
      settle_q        <= 8'h00;
      active_source_q <= `SCSS_SRC_HFINT;
      clk_gate_q      <= 1'b0;
      failsafe_q      <= 1'b0;
      cfg_src_q       <= `SCSS_SRC_HFINT;
      cfg_mode_q      <= `SCSS_EXT_CLK_HIGH;
      cfg_clkout_q    <= 1'b0;
      cfg_sec_xtal_q  <= 1'b0;
    end else if (ce) begin
      case (state_q)
        ST_BOOT: begin
          // Configuration is caught by the clock after reset release. [RL1]
          cfg_src_q      <= legal_src(reset_osc_select);
          cfg_mode_q     <= ext_osc_mode_select; // [RL2]
          cfg_clkout_q   <= clock_out_pin_enable;
          cfg_sec_xtal_q <= secondary_use_crystal;
          target_q       <= legal_src(reset_osc_select); // [RL10]
          settle_q       <= 8'h00;
          state_q        <= ST_QUAL;
        end
        ST_RUN: begin
          clk_gate_q <= 1'b1;
          if (active_lost) begin
            // Fail-safe: the dead source cannot be waited on. [RL5]
            active_source_q <= `SCSS_SRC_HFINT;
            target_q        <= `SCSS_SRC_HFINT;
            failsafe_q      <= 1'b1; // [RL17]
            clk_gate_q      <= 1'b0;
            state_q         <= ST_GATE;
          end else if (sw_switch &&
                       legal_src(avs_writedata[2:0]) != active_source_q) begin
            target_q <= legal_src(avs_writedata[2:0]); // [RL9] [RL11]
            settle_q <= 8'h00;
            state_q  <= ST_QUAL;
          end
        end
        ST_QUAL: begin
          if (settle_q != INT_SETTLE[7:0]) begin
            settle_q <= settle_q + 8'h01;
          end
          if (active_lost) begin
            active_source_q <= `SCSS_SRC_HFINT;
            target_q        <= `SCSS_SRC_HFINT;
            failsafe_q      <= 1'b1;
            clk_gate_q      <= 1'b0;
            state_q         <= ST_GATE;
          end else if (target_ready) begin
            clk_gate_q      <= 1'b0; // [RL16]
            active_source_q <= target_q;
            state_q         <= ST_GATE;
          end
        end
        ST_GATE: begin
          clk_gate_q <= 1'b1;
          state_q    <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ============================================================
  // Pin roles follow the active source; crystal drive also covers a source in qualification.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_mode_q              <= `SCSS_EXT_CLK_HIGH;
      primary_xtal_drive_q    <= 1'b0;
      secondary_xtal_drive_q  <= 1'b0;
      primary_in_is_gpio_q    <= 1'b0;
      primary_out_is_clkout_q <= 1'b0;
      primary_out_is_gpio_q   <= 1'b0;
    end else if (ce) begin
      ext_mode_q <= cfg_mode_q; // [RL3]
      // Crystal drive starts during qualification so the crystal can start up. [RL4]
      primary_xtal_drive_q   <= mon_enable[0] && is_crystal(cfg_mode_q);
      secondary_xtal_drive_q <= mon_enable[1] && cfg_sec_xtal_q; // [RL8]
      primary_in_is_gpio_q   <= is_internal(active_source_q) ||
                                active_source_q == `SCSS_SRC_SEC; // [RL12]
      primary_out_is_clkout_q <= (active_source_q != `SCSS_SRC_EXT ||
                                  !is_crystal(cfg_mode_q)) && cfg_clkout_q; // [RL13]
      primary_out_is_gpio_q   <= (active_source_q != `SCSS_SRC_EXT ||
                                  !is_crystal(cfg_mode_q)) && !cfg_clkout_q; // [RL12]
    end
  end

  // ============================================================
  // Software registers, interrupt status and mask.
  // A status read clears the whole status word; only an event in that same cycle survives.
  // Events are gated by ce, so a frozen block raises nothing.
  wire [`SCSS_IRQ_W-1:0] irq_set;
  wire                   stat_rd = avs_read && !avs_waitrequest &&
                                   word_idx == `SCSS_REG_IRQ_STAT;
  assign irq_set[`SCSS_IRQ_FAIL] = ce & fail_evt;
  assign irq_set[`SCSS_IRQ_DONE] = ce & done_evt;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      new_osc_select_q     <= `SCSS_SRC_HFINT;
      hf_freq_select_reg_q <= `SCSS_FREQ_RST;
      hf_fine_tune_reg_q   <= `SCSS_TUNE_RST;
      irq_stat_q           <= {`SCSS_IRQ_W{1'b0}};
      irq_mask_q           <= {`SCSS_IRQ_W{1'b0}};
      hf_freq_out_q        <= `SCSS_FREQ_RST;
      hf_tune_out_q        <= `SCSS_TUNE_RST;
      irq_q                <= 1'b0;
    end else if (ce) begin
      if (wr_done) begin
        case (word_idx)
          `SCSS_REG_CTRL:     new_osc_select_q <= avs_writedata[2:0];
          `SCSS_REG_FREQ: begin
            // Codes above the top range are not taken. [RL14]
            if (avs_writedata[3:0] <= `SCSS_FREQ_MAX) begin
              hf_freq_select_reg_q <= avs_writedata[3:0];
            end
          end
          `SCSS_REG_TUNE:     hf_fine_tune_reg_q <= avs_writedata[5:0]; // [RL14]
          `SCSS_REG_IRQ_MASK: irq_mask_q <= avs_writedata[`SCSS_IRQ_W-1:0];
          default: begin
          end
        endcase
      end
      if (stat_rd) begin
        irq_stat_q <= irq_set; // [RL17]
      end else begin
        irq_stat_q <= irq_stat_q | irq_set;
      end
      hf_freq_out_q <= hf_freq_select_reg_q;
      hf_tune_out_q <= hf_fine_tune_reg_q;
      irq_q         <= |((stat_rd ? irq_set : (irq_stat_q | irq_set)) & irq_mask_q);
    end
  end

  // ============================================================
  // Avalon slave: one wait cycle, then data stands with waitrequest low.
  // Status packs ready, lost, fail-safe, state, target and source in 13 bits.
  // Unmapped words read as zero and ignore writes.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (ce) begin
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= 32'h00000000;
        if (avs_read) begin
          case (word_idx)
            `SCSS_REG_CTRL:     avs_readdata[2:0] <= new_osc_select_q;
            `SCSS_REG_STATUS:   avs_readdata[12:0] <= {mon_ready, mon_lost, failsafe_q,
                                                       state_q, target_q, active_source_q};
            `SCSS_REG_FREQ:     avs_readdata[3:0] <= hf_freq_select_reg_q;
            `SCSS_REG_TUNE:     avs_readdata[5:0] <= hf_fine_tune_reg_q;
            `SCSS_REG_IRQ_STAT: avs_readdata[1:0] <= irq_stat_q;
            `SCSS_REG_IRQ_MASK: avs_readdata[1:0] <= irq_mask_q;
            default:            avs_readdata <= 32'h00000000;
          endcase
        end
      end else begin
        avs_waitrequest <= 1'b1;
        if (bus_done) begin
          avs_readdata <= avs_readdata;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [scss_clk_select_sva.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scss_defs.vh"
// ============================================================
// Port checker for the clock source selector.
module scss_clk_select_sva (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       clock_out_pin_enable,
  input wire logic       secondary_use_crystal,
  input wire logic [2:0] active_source_q,
  input wire logic [2:0] ext_mode_q,
  input wire logic       primary_xtal_drive_q,
  input wire logic       secondary_xtal_drive_q,
  input wire logic       primary_in_is_gpio_q,
  input wire logic       primary_out_is_clkout_q,
  input wire logic       primary_out_is_gpio_q,
  input wire logic       clk_gate_q,
  input wire logic [3:0] hf_freq_out_q,
  input wire logic       irq_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Pin roles are judged only once the gate and the source have rested, since the flags lag.
  sequence s_settled;
    clk_gate_q && $past(clk_gate_q) && $stable(active_source_q);
  endsequence
  property p_wait_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_in_gpio;
    s_settled |-> primary_in_is_gpio_q == (active_source_q != `SCSS_SRC_EXT);
  endproperty
  property p_clkout;
    s_settled and active_source_q != `SCSS_SRC_EXT |-> primary_out_is_clkout_q
      == clock_out_pin_enable && primary_out_is_gpio_q != clock_out_pin_enable;
  endproperty
  property p_pri_drive; primary_xtal_drive_q |-> ext_mode_q >= `SCSS_XTAL_LOW; endproperty
  property p_sec_drive; secondary_xtal_drive_q |-> secondary_use_crystal; endproperty
  property p_switch_gated; !$stable(active_source_q) |-> !clk_gate_q; endproperty
  property p_gate_short; $fell(clk_gate_q) |=> clk_gate_q; endproperty
  property p_mode_boot; !$stable(ext_mode_q) |-> !clk_gate_q; endproperty
  property p_freq_max; hf_freq_out_q <= `SCSS_FREQ_MAX; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  a_in_gpio: assert property (p_in_gpio) else $error("input pin role wrong");
  a_clkout: assert property (p_clkout) else $error("output pin role wrong");
  a_pri_drive: assert property (p_pri_drive) else $error("primary drive in clock mode");
  a_sec_drive: assert property (p_sec_drive) else $error("secondary drive wrong");
  a_switch_gated: assert property (p_switch_gated) else $error("ungated switch");
  a_gate_short: assert property (p_gate_short) else $error("gate low too long");
  a_mode_boot: assert property (p_mode_boot) else $error("mode moved at run time");
  a_freq_max: assert property (p_freq_max) else $error("frequency code too large");
  c_lf: cover property (active_source_q == `SCSS_SRC_LFINT);
  c_fail: cover property ($past(active_source_q) == `SCSS_SRC_EXT && active_source_q == 3'h0);
  c_xtal: cover property (primary_xtal_drive_q);
  c_irq: cover property ($rose(irq_q));
endmodule
bind scss_clk_select scss_clk_select_sva chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .clock_out_pin_enable(clock_out_pin_enable), .secondary_use_crystal(secondary_use_crystal),
  .active_source_q(active_source_q), .ext_mode_q(ext_mode_q), .irq_q(irq_q),
  .primary_xtal_drive_q(primary_xtal_drive_q), .secondary_xtal_drive_q(secondary_xtal_drive_q),
  .primary_in_is_gpio_q(primary_in_is_gpio_q), .primary_out_is_gpio_q(primary_out_is_gpio_q),
  .primary_out_is_clkout_q(primary_out_is_clkout_q), .clk_gate_q(clk_gate_q),
  .hf_freq_out_q(hf_freq_out_q));
`default_nettype wire

// [scss_clk_select_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "scss_defs.vh"
// ============================================================
// Bench for the clock source selector.
module scss_clk_select_tb;
  localparam int OSC_STARTUP_TIMER = 4;
  logic        clk_sys = 1'b0, arst_n = 1'b0, clkout_en = 1'b0, sec_cry = 1'b0;
  logic        pri_pin, sec_pin, pri_run = 1'b1, sec_run = 1'b1;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, irq_q, px;
  logic [2:0]  rosc = 3'h0, mode = 3'h0, active_source_q, ext_mode_q, s;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, rnd;
  logic [3:0]  hf_freq_out_q, f;
  logic [5:0]  hf_tune_out_q;
  logic        pdrv, sdrv, in_gpio, out_clk, out_gpio, gate;
  int          fails = 0, checked = 0, seed = 32'hEA443AC5, pri_rises, sec_rises, pri_r0;
  always #25 clk_sys = !clk_sys;
  scss_osc_model pri (.clk_sys(clk_sys), .run(pri_run), .crystal(mode >= `SCSS_XTAL_LOW),
    .drive(pdrv), .osc(pri_pin), .rises(pri_rises));
  scss_osc_model sec (.clk_sys(clk_sys), .run(sec_run), .crystal(sec_cry), .drive(sdrv),
    .osc(sec_pin), .rises(sec_rises));
  scss_clk_select #(.OST_EDGES(OSC_STARTUP_TIMER), .LOSS_CYCLES(16), .INT_SETTLE(2)) dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .reset_osc_select(rosc),
    .ext_osc_mode_select(mode), .clock_out_pin_enable(clkout_en), .primary_osc_in_pin(pri_pin),
    .secondary_clock_input(sec_pin), .secondary_use_crystal(sec_cry),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .active_source_q(active_source_q),
    .ext_mode_q(ext_mode_q), .primary_xtal_drive_q(pdrv), .secondary_xtal_drive_q(sdrv),
    .primary_in_is_gpio_q(in_gpio), .primary_out_is_clkout_q(out_clk),
    .primary_out_is_gpio_q(out_gpio), .clk_gate_q(gate), .hf_freq_out_q(hf_freq_out_q),
    .hf_tune_out_q(hf_tune_out_q), .irq_q(irq_q));
  // ============================================================
  // Expectations and shared tasks.
  function automatic logic [2:0] exp_src(input logic [2:0] r);
    return (r > 3'h3) ? `SCSS_SRC_HFINT : r;
  endfunction
  function automatic logic [3:0] next_freq(input logic [3:0] old, input logic [3:0] v);
    return (v <= `SCSS_FREQ_MAX) ? v : old;
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One Avalon transfer; the request is held until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [2:0] w, input logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge clk_sys);
    avs_address <= {w, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus_wait", 2, n);
  endtask
  task automatic wait_src(input logic [2:0] want);
    int n = 0;
    while ((active_source_q !== want || gate !== 1'b1) && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    chk("active_source", want, active_source_q);
  endtask
  task automatic do_reset(input logic [2:0] r, input logic [2:0] m);
    @(posedge clk_sys);
    rnd = $random(seed);
    arst_n <= 1'b0;
    rosc <= r;
    mode <= m;
    clkout_en <= rnd[0];
    sec_cry <= rnd[1];
    repeat (16) @(posedge clk_sys);
    chk("waitrequest_rst", 1, avs_waitrequest);
    chk("tune_out_rst", `SCSS_TUNE_RST, hf_tune_out_q);
    chk("mode_rst", 3'h2, ext_mode_q);
    pri_r0 = pri_rises;
    arst_n <= 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The whole run needs under 1000 cycles; the watchdog allows far more.
  initial begin
    repeat (40000) @(posedge clk_sys);
    fails++;
    tally_and_finish();
  end
  // ============================================================
  // Boot from each configured source and mode, then lose the external clock.
  initial begin
    for (int i = 0; i < 9; i++) begin
      do_reset((i < 6) ? `SCSS_SRC_EXT : (i == 6) ? `SCSS_SRC_LFINT : (i == 7) ? 3'h3 : 3'h7,
               3'(i % 6));
      s = exp_src(rosc);
      wait_src(s);
      px = (s == `SCSS_SRC_EXT) && (mode >= `SCSS_XTAL_LOW);
      if (px) chk("ost_edges", 1, (pri_rises - pri_r0) >= OSC_STARTUP_TIMER);
      repeat (2) @(posedge clk_sys);
      chk("ext_mode", mode, ext_mode_q);
      chk("pri_drive", px, pdrv);
      chk("in_gpio", s != `SCSS_SRC_EXT, in_gpio);
      chk("out_clkout", clkout_en && !px, out_clk);
      chk("out_gpio", !clkout_en && !px, out_gpio);
      if (s == `SCSS_SRC_EXT || s == `SCSS_SRC_SEC) begin
        pri_run <= 1'b0;
        sec_run <= 1'b0;
        wait_src(`SCSS_SRC_HFINT);
        chk("irq_masked", 0, irq_q);
        bus(1'b0, `SCSS_REG_IRQ_STAT, 32'h0, rd);
        chk("fail_flag", 1, rd[`SCSS_IRQ_FAIL]);
        pri_run <= 1'b1;
        sec_run <= 1'b1;
      end
      $display("test boot %0d done", i);
    end
    // Registers: reset values, the frequency limit, tuning and unmapped words.
    bus(1'b0, `SCSS_REG_FREQ, 32'h0, rd);
    chk("freq_rst", `SCSS_FREQ_RST, rd);
    bus(1'b0, `SCSS_REG_TUNE, 32'h0, rd);
    chk("tune_rst", `SCSS_TUNE_RST, rd);
    f = `SCSS_FREQ_RST;
    for (int k = 0; k < 8; k++) begin
      rnd = $random(seed);
      rnd[3:0] = (k == 0) ? 4'h8 : (k == 1) ? 4'h9 : rnd[3:0];
      bus(1'b1, `SCSS_REG_FREQ, {28'h0, rnd[3:0]}, rd);
      f = next_freq(f, rnd[3:0]);
      bus(1'b0, `SCSS_REG_FREQ, 32'h0, rd);
      chk("freq", f, rd);
      chk("freq_out", f, hf_freq_out_q);
      bus(1'b1, `SCSS_REG_TUNE, {26'h0, rnd[9:4]}, rd);
      bus(1'b0, `SCSS_REG_TUNE, 32'h0, rd);
      chk("tune", rnd[9:4], rd);
      chk("tune_out", rnd[9:4], hf_tune_out_q);
      bus(1'b1, 3'(6 + k % 2), rnd, rd);
      bus(1'b0, 3'(6 + k % 2), 32'h0, rd);
      chk("unmapped", 0, rd);
    end
    $display("test registers done");
    // Run-time switches with the done interrupt unmasked.
    bus(1'b0, `SCSS_REG_IRQ_STAT, 32'h0, rd);
    bus(1'b1, `SCSS_REG_IRQ_MASK, 32'h2, rd);
    bus(1'b1, `SCSS_REG_CTRL, {29'h0, `SCSS_SRC_LFINT}, rd);
    chk("irq_idle", 0, irq_q);
    wait_src(`SCSS_SRC_LFINT);
    repeat (2) @(posedge clk_sys);
    chk("irq_done", 1, irq_q);
    bus(1'b0, `SCSS_REG_IRQ_STAT, 32'h0, rd);
    chk("irq_stat", 32'h2, rd);
    repeat (2) @(posedge clk_sys);
    chk("irq_cleared", 0, irq_q);
    bus(1'b1, `SCSS_REG_CTRL, {29'h0, `SCSS_SRC_SEC}, rd);
    wait_src(`SCSS_SRC_SEC);
    bus(1'b1, `SCSS_REG_CTRL, {29'h0, `SCSS_SRC_HFINT}, rd);
    wait_src(`SCSS_SRC_HFINT);
    bus(1'b0, `SCSS_REG_CTRL, 32'h0, rd);
    chk("ctrl", `SCSS_SRC_HFINT, rd);
    $display("test switching done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [scss_defs.vh]
`ifndef SCSS_DEFS_VH
`define SCSS_DEFS_VH
// ============================================================
// Source codes shared by configuration, software and status.
`define SCSS_SRC_HFINT     3'h0
`define SCSS_SRC_EXT       3'h1
`define SCSS_SRC_LFINT     3'h2
`define SCSS_SRC_SEC       3'h3
// ============================================================
// External oscillator modes.
`define SCSS_EXT_CLK_LOW   3'h0
`define SCSS_EXT_CLK_MED   3'h1
`define SCSS_EXT_CLK_HIGH  3'h2
`define SCSS_XTAL_LOW      3'h3
`define SCSS_XTAL_MED      3'h4
`define SCSS_XTAL_HIGH     3'h5
// ============================================================
// Register word indices.
`define SCSS_REG_CTRL      3'h0
`define SCSS_REG_STATUS    3'h1
`define SCSS_REG_FREQ      3'h2
`define SCSS_REG_TUNE      3'h3
`define SCSS_REG_IRQ_STAT  3'h4
`define SCSS_REG_IRQ_MASK  3'h5
// ============================================================
// Field widths, positions and reset values.
`define SCSS_FREQ_W        4
`define SCSS_TUNE_W        6
`define SCSS_FREQ_RST      4'h0
`define SCSS_TUNE_RST      6'h20
`define SCSS_FREQ_MAX      4'h8
`define SCSS_IRQ_FAIL      0
`define SCSS_IRQ_DONE      1
`define SCSS_IRQ_W         2
// ============================================================
// Timing defaults in clk_sys cycles or source edges.
`define SCSS_OST_EDGES     1024
`define SCSS_LOSS_CYCLES   1024
`define SCSS_INT_SETTLE    16
`endif

// [scss_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// Slow external source; a crystal swings only while it is driven.
module scss_osc_model (
  input  wire logic clk_sys,
  input  wire logic run,
  input  wire logic crystal,
  input  wire logic drive,
  output var  logic osc,
  output var  int   rises
);
  logic [1:0] cnt_q = 2'h0;
  initial begin
    osc = 1'b0;
    rises = 0;
  end
  // A stopped source holds its level, as a dead clock does.
  always @(posedge clk_sys) begin
    if (run && (!crystal || drive)) begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h2) begin
        cnt_q <= 2'h0;
        osc <= !osc;
        rises <= rises + (osc ? 0 : 1);
      end
    end
  end
endmodule
`default_nettype wire

// [scss_src_mon.v]
`timescale 1ns/1ps
`default_nettype none
`include "scss_defs.vh"
module scss_src_mon #(
  parameter OST_EDGES   = `SCSS_OST_EDGES,
  parameter LOSS_CYCLES = `SCSS_LOSS_CYCLES
) (
  input  wire clk_sys,
  input  wire arst_n,
  input  wire ce,
  input  wire enable,
  input  wire use_ost,
  input  wire src_level,
  output reg  ready_q,
  output reg  lost_q
);
  reg        level_q;
  reg [15:0] edge_cnt_q;
  reg [15:0] idle_cnt_q;
  wire       edge_seen = src_level & ~level_q;

  // ============================================================
  // Edge counting for start-up qualification and loss detection.
  // Loss is judged in clk_sys cycles, so it works even when the
  // source itself has stopped and gives no edges to count with.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      level_q    <= 1'b0;
      edge_cnt_q <= 16'h0000;
      idle_cnt_q <= 16'h0000;
      ready_q    <= 1'b0;
      lost_q     <= 1'b0;
    end else if (ce) begin
      level_q <= src_level;
      if (!enable) begin
        edge_cnt_q <= 16'h0000;
        idle_cnt_q <= 16'h0000;
        ready_q    <= 1'b0;
        lost_q     <= 1'b0;
      end else if (edge_seen) begin
        idle_cnt_q <= 16'h0000;
        lost_q     <= 1'b0;
        if (!ready_q) begin
          edge_cnt_q <= edge_cnt_q + 16'h0001;
          // Crystals wait out the start-up count; logic clocks need one edge. [RL6]
          if (!use_ost || edge_cnt_q == OST_EDGES[15:0] - 16'h0001) begin
            ready_q <= 1'b1;
          end
        end
      end else if (idle_cnt_q == LOSS_CYCLES[15:0] - 16'h0001) begin
        lost_q     <= 1'b1; // [RL5]
        ready_q    <= 1'b0;
        edge_cnt_q <= 16'h0000;
      end else begin
        idle_cnt_q <= idle_cnt_q + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire
